// ---- rtl/hws_pkg.sv ----
// Constants and register map for the row valid strobe gating block.
package hws_pkg;

  // Register offsets on the serial control register port.
  localparam logic [7:0] HWS_ADDR_SLOT  = 8'h16;
  localparam logic [7:0] HWS_ADDR_START = 8'h17;
  localparam logic [7:0] HWS_ADDR_END   = 8'h18;

  // Values after reset.
  localparam logic [7:0] HWS_RST_SLOT  = 8'h03;
  localparam logic [7:0] HWS_RST_START = 8'h2D;
  localparam logic [7:0] HWS_RST_END   = 8'hCD;

  // Field slot division register layout.
  localparam int HWS_MODE_LSB = 0;
  localparam int HWS_INTV_LSB = 2;

  // Field mode codes.
  localparam logic [1:0] HWS_MODE_OFF  = 2'h0;
  localparam logic [1:0] HWS_MODE_ODD  = 2'h1;
  localparam logic [1:0] HWS_MODE_EVEN = 2'h2;
  localparam logic [1:0] HWS_MODE_FRM  = 2'h3;

  // Column counter width and the widest horizontal window in pixels.
  localparam int          HWS_COL_W   = 11;
  localparam logic [10:0] HWS_WIN_MAX = 11'h298;

  // Number of pin inputs passed through the synchroniser.
  localparam int HWS_SYNC_W = 4;

endpackage

// ---- rtl/hws_pin_sync.sv ----
// Two-flop synchroniser for pin inputs with a rising edge detector on bit 0.
`timescale 1ns/1ps
module hws_pin_sync (
  input  wire logic                           core_clk,  // Block clock.
  input  wire logic                           sys_rst,   // Asynchronous reset, high.
  input  wire logic [hws_pkg::HWS_SYNC_W-1:0] async_in,  // Pins from outside the domain.
  output logic      [hws_pkg::HWS_SYNC_W-1:0] sync_out,  // Synchronised levels.
  output logic                                rise_out,  // Pulse on bit 0 rising edge.
  output logic                                fall_out   // Pulse on bit 1 falling edge.
);
  import hws_pkg::*;

  typedef struct packed {
    logic [HWS_SYNC_W-1:0] meta;
    logic [HWS_SYNC_W-1:0] sync;
    logic [HWS_SYNC_W-1:0] prev;
  } hws_sync_s;

  hws_sync_s st_q;
  hws_sync_s st_d;

  // Shift the pins through two flops and keep one more stage for edges.
  always_comb begin
    st_d      = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  // State register.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Edges are found on the second and third stages only.
  assign sync_out = st_q.sync;
  assign rise_out = st_q.sync[0] & ~st_q.prev[0];
  assign fall_out = ~st_q.sync[1] & st_q.prev[1];

endmodule

// ---- rtl/hws_row_gate.sv ----
// Row valid strobe gating: field selection, slot decimation and line window.
`timescale 1ns/1ps
module hws_row_gate (
  input  wire logic       core_clk,          // Block clock, 100 MHz.
  input  wire logic       sys_rst,           // Asynchronous reset, high.
  input  wire logic [7:0] reg_addr,          // Register address.
  input  wire logic       reg_wr,            // Register write strobe.
  input  wire logic [7:0] reg_wdata,         // Register write data.
  output logic      [7:0] reg_rdata,         // Register read data, one cycle late.
  input  wire logic       pix_clk_in,        // Pixel clock pin.
  input  wire logic       line_active_in,    // Sensor line timing, high in a line.
  input  wire logic       field_odd_in,      // High during the odd field.
  input  wire logic       vsync_in,          // Field sync, falling edge ends a field.
  input  wire logic       scan_interlaced,   // High for interlaced scan.
  input  wire logic       single_frame_xfer, // Single frame transfer in progress.
  input  wire logic       fmt_qvga,          // Output format bit 5, 320x240.
  input  wire logic       fmt_qqvga,         // Quarter QVGA scaling.
  input  wire logic       fmt_strobe_low,    // Output format bit 3, active low.
  output logic            row_valid_strobe   // Row valid strobe to the host.
);
  import hws_pkg::*;

  typedef struct packed {
    logic [7:0]           slot_div;
    logic [7:0]           win_start;
    logic [7:0]           win_end;
    logic [7:0]           sh_slot_div;
    logic [7:0]           sh_start;
    logic [7:0]           sh_end;
    logic                 sh_qvga;
    logic                 sh_qqvga;
    logic [5:0]           slot;
    logic [HWS_COL_W-1:0] col;
    logic                 active;
    logic                 strobe;
    logic [7:0]           rdata;
  } hws_gate_s;

  hws_gate_s st_q;
  hws_gate_s st_d;

  logic [HWS_SYNC_W-1:0] pins;
  logic                  pix_rise;
  logic                  field_edge;
  logic                  line_on;
  logic                  odd_now;
  logic [HWS_COL_W-1:0]  start_px;
  logic [HWS_COL_W-1:0]  end_px;
  logic [HWS_COL_W-1:0]  limit_px;
  logic [1:0]            mode;
  logic [5:0]            intv;
  logic                  slot_hit;
  logic                  field_ok;

  // Converts a window register value to a pixel column at the given scale.
  function automatic logic [HWS_COL_W-1:0] to_px(input logic [7:0] v,
                                                 input logic       qvga,
                                                 input logic       qqvga);
    logic [HWS_COL_W-1:0] px;
    px = {3'h0, v};
    if (qqvga) begin
      px = {3'h0, v};
    end else if (qvga) begin
      px = {2'h0, v, 1'b0};
    end else begin
      px = {1'b0, v, 2'h0};
    end
    return px;
  endfunction

  // Pin inputs pass two flops; pixel clock rise and field end become pulses.
  hws_pin_sync hws_pin_sync_inst (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({field_odd_in, line_active_in, vsync_in, pix_clk_in}),
    .sync_out (pins),
    .rise_out (pix_rise),
    .fall_out (field_edge)
  );

  assign line_on = pins[2];
  assign odd_now = pins[3];

  // Window edges in pixels from the shadowed values.
  assign start_px = to_px(st_q.sh_start, st_q.sh_qvga, st_q.sh_qqvga);
  assign end_px   = to_px(st_q.sh_end, st_q.sh_qvga, st_q.sh_qqvga);
  assign limit_px = start_px + HWS_WIN_MAX;

  // Field gating from the shadowed mode and interval.
  assign mode     = st_q.sh_slot_div[HWS_MODE_LSB +: 2];
  assign intv     = st_q.sh_slot_div[HWS_INTV_LSB +: 6];
  assign slot_hit = (st_q.slot == 6'h00);

  always_comb begin
    case (mode)
      HWS_MODE_OFF: begin
        field_ok = single_frame_xfer;
      end
      HWS_MODE_ODD: begin
        field_ok = slot_hit && (!scan_interlaced || odd_now);
      end
      HWS_MODE_EVEN: begin
        field_ok = slot_hit && (!scan_interlaced || !odd_now);
      end
      HWS_MODE_FRM: begin
        field_ok = 1'b1;
      end
      default: begin
        field_ok = 1'b0;
      end
    endcase
  end

  // Next state: registers, shadows, slot and column counters, strobe.
  always_comb begin
    st_d = st_q;
    if (reg_wr) begin
      case (reg_addr)
        HWS_ADDR_SLOT: begin
          st_d.slot_div = reg_wdata;
        end
        HWS_ADDR_START: begin
          st_d.win_start = reg_wdata;
        end
        HWS_ADDR_END: begin
          st_d.win_end = reg_wdata;
        end
        default: begin
          st_d.slot_div = st_q.slot_div;
        end
      endcase
    end
    case (reg_addr)
      HWS_ADDR_SLOT: begin
        st_d.rdata = st_q.slot_div;
      end
      HWS_ADDR_START: begin
        st_d.rdata = st_q.win_start;
      end
      HWS_ADDR_END: begin
        st_d.rdata = st_q.win_end;
      end
      default: begin
        st_d.rdata = 8'h00;
      end
    endcase
    // Settings move into the working copy only at a field boundary.
    if (field_edge) begin
      st_d.sh_slot_div = st_q.slot_div;
      st_d.sh_start    = st_q.win_start;
      st_d.sh_end      = st_q.win_end;
      st_d.sh_qvga     = fmt_qvga;
      st_d.sh_qqvga    = fmt_qqvga;
      if ((st_q.slot + 6'h01) >= intv) begin
        st_d.slot = 6'h00;
      end else begin
        st_d.slot = st_q.slot + 6'h01;
      end
    end
    // Column counter runs on pixel clock edges inside a line.
    if (!line_on) begin
      st_d.col = '0;
    end else if (pix_rise && (st_q.col != {HWS_COL_W{1'b1}})) begin
      st_d.col = st_q.col + 11'h001;
    end
    // Strobe only gates; data and pixel clock are never touched here.
    st_d.active = field_ok && line_on && (st_q.col >= start_px)
                  && (st_q.col < end_px) && (st_q.col < limit_px);
    st_d.strobe = st_d.active ^ fmt_strobe_low;
  end

  // State register with documented reset values.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q           <= '0;
      st_q.slot_div    <= HWS_RST_SLOT;
      st_q.win_start   <= HWS_RST_START;
      st_q.win_end     <= HWS_RST_END;
      st_q.sh_slot_div <= HWS_RST_SLOT;
      st_q.sh_start  <= HWS_RST_START;
      st_q.sh_end    <= HWS_RST_END;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata        = st_q.rdata;
  assign row_valid_strobe = st_q.strobe;

  // Off mode keeps the strobe inactive unless a single frame transfer is in progress.
  off_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_OFF) && !single_frame_xfer && !field_edge |=> !st_q.active)
    else $error("strobe active in off mode");

  // Odd mode blocks the even field in interlaced scan.
  odd_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_ODD) && scan_interlaced && !odd_now && !field_edge |=> !st_q.active)
    else $error("strobe active in even field in odd mode");

  // Even mode blocks the odd field in interlaced scan.
  even_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_EVEN) && scan_interlaced && odd_now && !field_edge |=> !st_q.active)
    else $error("strobe active in odd field in even mode");

  // Outside the chosen slot no strobe appears in odd or even mode.
  slot_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode[0] ^ mode[1]) && (st_q.slot != 6'h00) && !field_edge |=> !st_q.active)
    else $error("strobe active outside selected slot");

  // Frame mode strobes whenever the column is inside the window.
  frame_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_FRM) && line_on && (st_q.col >= start_px) && (st_q.col < end_px)
    && (st_q.col < limit_px) && !field_edge |=> st_q.active)
    else $error("strobe missing in frame mode window");

  // The strobe starts no earlier than the scaled start column.
  window_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_q.active) |-> ($past(st_q.col) >= $past(start_px)))
    else $error("strobe started before window start");

  // The window never exceeds the widest span.
  window_span_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.active |-> ($past(st_q.col) < $past(limit_px)))
    else $error("strobe window wider than limit");

  // Output polarity follows the format bit.
  strobe_pol_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 (row_valid_strobe == (st_q.active ^ $past(fmt_strobe_low))))
    else $error("strobe polarity wrong");

  // Working window copy changes only at a field boundary.
  shadow_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !field_edge |=> $stable(st_q.sh_start) && $stable(st_q.sh_end)
    && $stable(st_q.sh_slot_div))
    else $error("window changed away from field boundary");

  // The strobe ends before the scaled end column.
  window_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.active |-> ($past(st_q.col) < $past(end_px)))
    else $error("strobe ran past window end");

  // The strobe is only raised where the field gating allowed it.
  field_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.active |-> $past(field_ok))
    else $error("strobe active without field gating");

  // Outside a line no strobe appears.
  line_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !line_on |=> !st_q.active)
    else $error("strobe active outside a line");

  // Off mode with a single frame transfer still strobes inside the window.
  off_xfer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_OFF) && single_frame_xfer && line_on && (st_q.col >= start_px)
    && (st_q.col < end_px) && (st_q.col < limit_px) |=> st_q.active)
    else $error("strobe missing during single frame transfer");

  // Progressive odd mode strobes inside the window in the shown slot.
  prog_slot_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode == HWS_MODE_ODD) && !scan_interlaced && (st_q.slot == 6'h00) && line_on
    && (st_q.col >= start_px) && (st_q.col < end_px) && (st_q.col < limit_px) |=> st_q.active)
    else $error("strobe missing in progressive shown slot");

  // Intervals of zero and one keep every field in the shown slot.
  slot_every_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    field_edge && (intv <= 6'h01) |=> (st_q.slot == 6'h00))
    else $error("slot moved with interval one");

  // Interval two steps from the shown slot to the skipped one.
  slot_pair_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    field_edge && (intv == 6'h02) && (st_q.slot == 6'h00) |=> (st_q.slot == 6'h01))
    else $error("slot did not step with interval two");

  // Scale selection changes only at a field boundary.
  scale_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !field_edge |=> $stable(st_q.sh_qvga) && $stable(st_q.sh_qqvga))
    else $error("scale changed away from field boundary");

  // A start register write lands one cycle after its strobe.
  start_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && (reg_addr == HWS_ADDR_START) |=> (st_q.win_start == $past(reg_wdata)))
    else $error("start register write lost");

  // An end register write lands one cycle after its strobe.
  end_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && (reg_addr == HWS_ADDR_END) |=> (st_q.win_end == $past(reg_wdata)))
    else $error("end register write lost");

endmodule

// ---- verification/hws_video_src.sv ----
// Video source model that paces fields and lines and counts strobed pixels.
`timescale 1ns/1ps
module hws_video_src (
  input  wire logic core_clk,         // Pacing clock.
  input  wire logic pol_low,          // Strobe is active low when set.
  input  wire logic row_valid_strobe, // Strobe from the block.
  output logic      pix_clk_in,       // Pixel clock, still outside lines.
  output logic      line_active_in,   // High during a line.
  output logic      field_odd_in,     // Field parity.
  output logic      vsync_in          // Falling edge ends a field.
);
  // All pins idle low at time zero.
  initial begin
    pix_clk_in = 1'b0;
    line_active_in = 1'b0;
    field_odd_in = 1'b0;
    vsync_in = 1'b0;
  end
  // Pulses field sync; its falling edge opens a field of the given parity.
  task automatic boundary(input logic odd);
    @(negedge core_clk);
    field_odd_in = odd;
    vsync_in = 1'b1;
    repeat (6) @(negedge core_clk);
    vsync_in = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
  // Runs one line of n pixels at 160 ns and counts pixels seen with an active strobe.
  task automatic line(input int n, output int c);
    c = 0;
    line_active_in = 1'b1;
    repeat (4) @(negedge core_clk);
    repeat (n) begin
      pix_clk_in = 1'b1;
      repeat (8) @(negedge core_clk);
      if ((row_valid_strobe ^ pol_low) === 1'b1) c++;
      pix_clk_in = 1'b0;
      repeat (8) @(negedge core_clk);
    end
    line_active_in = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ---- verification/hws_row_gate_bench.sv ----
// Self-checking bench for the row valid strobe gating block.
`timescale 1ns/1ps
module hws_row_gate_bench;
  import hws_pkg::*;
  logic       core_clk          = 1'b0;
  logic       sys_rst           = 1'b1;
  logic [7:0] reg_addr          = 8'h00;
  logic       reg_wr            = 1'b0;
  logic [7:0] reg_wdata         = 8'h00;
  logic       scan_interlaced   = 1'b1;
  logic       single_frame_xfer = 1'b0;
  logic       fmt_qvga          = 1'b0;
  logic       fmt_qqvga         = 1'b0;
  logic       fmt_strobe_low    = 1'b0;
  logic [7:0] reg_rdata;
  logic       pix_clk_in;
  logic       line_active_in;
  logic       field_odd_in;
  logic       vsync_in;
  logic       row_valid_strobe;
  int         err_total         = 0;
  int         tests_run         = 0;
  int         ncol              = 24;
  int         c1;
  int         c2;
  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;
  hws_row_gate hws_row_gate_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_clk_in(pix_clk_in),
    .line_active_in(line_active_in), .field_odd_in(field_odd_in), .vsync_in(vsync_in),
    .scan_interlaced(scan_interlaced), .single_frame_xfer(single_frame_xfer),
    .fmt_qvga(fmt_qvga), .fmt_qqvga(fmt_qqvga), .fmt_strobe_low(fmt_strobe_low),
    .row_valid_strobe(row_valid_strobe));
  hws_video_src hws_video_src_inst (.core_clk(core_clk), .pol_low(fmt_strobe_low),
    .row_valid_strobe(row_valid_strobe), .pix_clk_in(pix_clk_in),
    .line_active_in(line_active_in), .field_odd_in(field_odd_in), .vsync_in(vsync_in));
  // Compares a register byte.
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Compares a pixel count worked out by the bench.
  task automatic chkn(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // One register write, strobe held for one clock.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // Registered read: data is taken after the address has been sampled.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    repeat (2) @(negedge core_clk);
    chk8("reg_rdata", e, reg_rdata);
  endtask
  // One field with an optional boundary in front, returning strobed pixels.
  task automatic fld(input logic odd, input logic bnd, output int c);
    if (bnd) hws_video_src_inst.boundary(odd);
    hws_video_src_inst.line(ncol, c);
  endtask
  // Writes a field mode setting and checks one field of given parity.
  task automatic mode_t(input logic [7:0] div, input logic odd, input int e);
    wr(HWS_ADDR_SLOT, div);
    fld(odd, 1'b1, c1);
    chkn("strobed pixels", e, c1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cuts a hang short well past the expected 0.32 ms of traffic.
  initial begin
    #800000;
    err_total++;
    conclude();
  end
  // Main sequence.
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(8'h16, 8'h03);
    rd(8'h17, 8'h2D);
    rd(8'h18, HWS_RST_END);
    wr(8'h20, 8'h5A);
    rd(8'h20, 8'h00);
    $display("test registers done");
    ncol = 830;
    fld(1'b1, 1'b1, c1);
    chkn("reset window", 640, c1);
    // Start at column 4 so all 664 columns of the widest span are clocked pixels.
    wr(HWS_ADDR_START, 8'h01);
    wr(HWS_ADDR_END, 8'hFF);
    rd(HWS_ADDR_END, 8'hFF);
    ncol = 700;
    fld(1'b1, 1'b1, c1);
    chkn("widest window", 664, c1);
    $display("test window size done");
    ncol = 24;
    wr(HWS_ADDR_START, 8'h01);
    wr(HWS_ADDR_END, 8'h03);
    mode_t(8'h03, 1'b1, 8);
    fmt_qvga = 1'b1;
    mode_t(8'h03, 1'b1, 4);
    fmt_qqvga = 1'b1;
    mode_t(8'h03, 1'b1, 2);
    fmt_qvga = 1'b0;
    fmt_qqvga = 1'b0;
    fmt_strobe_low = 1'b1;
    mode_t(8'h03, 1'b1, 8);
    fmt_strobe_low = 1'b0;
    wr(HWS_ADDR_END, 8'h05);
    fld(1'b1, 1'b0, c1);
    chkn("before boundary", 8, c1);
    fld(1'b1, 1'b1, c1);
    chkn("after boundary", 16, c1);
    wr(HWS_ADDR_END, 8'h03);
    $display("test scale and timing done");
    mode_t(8'h00, 1'b1, 0);
    single_frame_xfer = 1'b1;
    mode_t(8'h00, 1'b1, 8);
    single_frame_xfer = 1'b0;
    mode_t(8'h05, 1'b1, 8);
    mode_t(8'h05, 1'b0, 0);
    mode_t(8'h06, 1'b0, 8);
    mode_t(8'h06, 1'b1, 0);
    mode_t(8'h0B, 1'b1, 8);
    mode_t(8'h0B, 1'b0, 8);
    scan_interlaced = 1'b0;
    wr(HWS_ADDR_SLOT, 8'h09);
    fld(1'b1, 1'b1, c1);
    fld(1'b0, 1'b1, c2);
    chkn("two-field sum", 8, c1 + c2);
    chkn("two-field product", 0, c1 * c2);
    wr(HWS_ADDR_SLOT, 8'h05);
    fld(1'b1, 1'b1, c1);
    fld(1'b0, 1'b1, c2);
    chkn("every field sum", 16, c1 + c2);
    $display("test field modes done");
    conclude();
  end
endmodule
